// ==== design/lsdmp_regs.vh ====
// constants for the load-store data memory port
`ifndef LSDMP_REGS_VH
`define LSDMP_REGS_VH
`define LSDMP_DATA_W 32
`define LSDMP_MAU_W 8
`define LSDMP_LANES 4
`define LSDMP_ADDR_W 12
`define LSDMP_WADDR_W 10
`define LSDMP_OFS_W 2
`define LSDMP_OP_W 3
`define LSDMP_OP_LDW 3'h0
`define LSDMP_OP_LOAD_HALF_UNSIGNED_OP 3'h1
`define LSDMP_OP_LOAD_BYTE_UNSIGNED_OP 3'h2
`define LSDMP_OP_LDH 3'h3
`define LSDMP_OP_LDQ 3'h4
`define LSDMP_OP_STW 3'h5
`define LSDMP_OP_STH 3'h6
`define LSDMP_OP_STQ 3'h7
`define LSDMP_MASK_NONE 4'h0
`define LSDMP_MASK_ALL 4'hf
`define LSDMP_RD_LATENCY 1
`endif

// ==== design/lsdmp_lane_steer.v ====
// byte-lane mask and write data alignment from op and offset
`timescale 1ns/10ps
`default_nettype none
`include "lsdmp_regs.vh"
module lsdmp_lane_steer (
  // request
  input wire [`LSDMP_OP_W-1:0] op,
  input wire [`LSDMP_OFS_W-1:0] byte_ofs,
  input wire [`LSDMP_DATA_W-1:0] store_data,
  // steered
  output reg [`LSDMP_LANES-1:0] lane_mask,
  output reg [`LSDMP_DATA_W-1:0] lane_data,
  output reg is_store
);
  function [`LSDMP_LANES-1:0] lsdmp_half_mask;
    input hi;
    begin
      lsdmp_half_mask = hi ? 4'hc : 4'h3;
    end
  endfunction

  function [`LSDMP_LANES-1:0] lsdmp_byte_mask;
    input [`LSDMP_OFS_W-1:0] ofs;
    begin
      lsdmp_byte_mask = 4'h1 << ofs;
    end
  endfunction

  always @* begin
    lane_mask = `LSDMP_MASK_ALL;
    lane_data = store_data;
    is_store = 1'b0;
    case (op)
      `LSDMP_OP_LDW: begin
        lane_mask = `LSDMP_MASK_ALL; // R14
      end
      `LSDMP_OP_STW: begin
        lane_mask = `LSDMP_MASK_ALL; // R14
        is_store = 1'b1;
      end
      `LSDMP_OP_LOAD_HALF_UNSIGNED_OP, `LSDMP_OP_LDH: begin
        lane_mask = lsdmp_half_mask(byte_ofs[1]); // R05
      end
      `LSDMP_OP_STH: begin
        lane_mask = lsdmp_half_mask(byte_ofs[1]); // R13
        lane_data = {2{store_data[15:0]}};
        is_store = 1'b1;
      end
      `LSDMP_OP_LOAD_BYTE_UNSIGNED_OP, `LSDMP_OP_LDQ: begin
        lane_mask = lsdmp_byte_mask(byte_ofs); // R05
      end
      `LSDMP_OP_STQ: begin
        lane_mask = lsdmp_byte_mask(byte_ofs); // R13
        lane_data = {4{store_data[7:0]}};
        is_store = 1'b1;
      end
      default: begin
        lane_mask = `LSDMP_MASK_ALL;
      end
    endcase
  end
endmodule // lsdmp_lane_steer
`default_nettype wire

// ==== design/lsdmp_port.v ====
// load-store unit side of the single-port data memory interface
// Function
// R01: memory returns read data one cycle later
// R02: memory output unregistered; unit registers it
// R03: 8-bit addressable unit, 32-bit data bus
// R04: word address drops two low bits
// R05: lane mask from offset and op type
// R06: memory honours per-byte lane enables
// R07: memory preloaded from image at configuration
// R08: access enable low only during access
// R09: memory idle while access enable high
// R10: write enable low on write, high read
// R11: four-bit mask, one bit per byte
// R12: mask width is data width over eight
// R13: partial lanes for byte and halfword ops
// R14: full word uses all lanes, same edge
`timescale 1ns/10ps
`default_nettype none
`include "lsdmp_regs.vh"
module lsdmp_port (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // request from the core
  input wire req_valid,
  input wire [`LSDMP_OP_W-1:0] req_op,
  input wire [`LSDMP_ADDR_W-1:0] req_byte_addr,
  input wire [`LSDMP_DATA_W-1:0] req_store_data,
  // load result to the core
  output reg load_valid,
  output reg [`LSDMP_DATA_W-1:0] load_data,
  // memory port
  output reg [`LSDMP_WADDR_W-1:0] mem_word_addr,
  output reg [`LSDMP_DATA_W-1:0] mem_write_data,
  output reg mem_access_enable_n,
  output reg mem_write_enable_n,
  output reg [`LSDMP_LANES-1:0] byte_lane_mask,
  input wire [`LSDMP_DATA_W-1:0] mem_read_data
);
  wire [`LSDMP_LANES-1:0] mask_w;
  wire [`LSDMP_DATA_W-1:0] data_w;
  wire store_w;
  reg pend_reg;
  reg [`LSDMP_OP_W-1:0] pend_op_reg;
  reg [`LSDMP_OFS_W-1:0] pend_ofs_reg;
  reg [`LSDMP_DATA_W-1:0] load_next;

  // lane pickers shared by the signed and unsigned load paths
  function [15:0] lsdmp_half_pick;
    input [`LSDMP_DATA_W-1:0] word;
    input hi;
    begin
      lsdmp_half_pick = hi ? word[31:16] : word[15:0];
    end
  endfunction

  function [7:0] lsdmp_byte_pick;
    input [`LSDMP_DATA_W-1:0] word;
    input [`LSDMP_OFS_W-1:0] ofs;
    begin
      case (ofs)
        2'h0: lsdmp_byte_pick = word[7:0];
        2'h1: lsdmp_byte_pick = word[15:8];
        2'h2: lsdmp_byte_pick = word[23:16];
        default: lsdmp_byte_pick = word[31:24];
      endcase
    end
  endfunction

  // sign or zero fill a narrow lane out to the full bus
  function [`LSDMP_DATA_W-1:0] lsdmp_extend16;
    input [15:0] half;
    input signed_op;
    begin
      lsdmp_extend16 = {{16{signed_op & half[15]}}, half};
    end
  endfunction

  function [`LSDMP_DATA_W-1:0] lsdmp_extend8;
    input [7:0] lane;
    input signed_op;
    begin
      lsdmp_extend8 = {{24{signed_op & lane[7]}}, lane};
    end
  endfunction

  // only a read cycle returns data worth capturing
  function lsdmp_is_read;
    input access_n;
    input write_n;
    begin
      lsdmp_is_read = ~access_n & write_n;
    end
  endfunction

  lsdmp_lane_steer u_steer (
    .op(req_op),
    .byte_ofs(req_byte_addr[`LSDMP_OFS_W-1:0]),
    .store_data(req_store_data),
    .lane_mask(mask_w),
    .lane_data(data_w),
    .is_store(store_w)
  );

  // every memory strobe leaves a flop, so address, data, mask and
  // enables settle together and the memory samples them on one edge
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_access_enable_n <= 1'b1;
    end else begin
      mem_access_enable_n <= ~req_valid; // R08
    end
  end

  // a load leaves the write enable high; only a store pulls it low
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_write_enable_n <= 1'b1;
    end else begin
      mem_write_enable_n <= ~(req_valid & store_w); // R10
    end
  end

  // address, data and mask hold between accesses to save toggling
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_word_addr <= {`LSDMP_WADDR_W{1'b0}};
    end else if (req_valid) begin
      mem_word_addr <= req_byte_addr[`LSDMP_ADDR_W-1:`LSDMP_OFS_W]; // R04
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_write_data <= {`LSDMP_DATA_W{1'b0}};
    end else if (req_valid) begin
      mem_write_data <= data_w; // R03
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      byte_lane_mask <= `LSDMP_MASK_NONE;
    end else if (req_valid) begin
      byte_lane_mask <= mask_w; // R11 R12 R14
    end
  end

  // the memory answers one cycle after the access edge, so a load is
  // captured exactly two cycles after the strobes went out
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= lsdmp_is_read(mem_access_enable_n, mem_write_enable_n); // R01
    end
  end

  // first stage: op and offset of the request now on the strobes
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_op_reg <= `LSDMP_OP_LDW;
      pend_ofs_reg <= 2'h0;
    end else begin
      pend_op_reg <= req_op;
      pend_ofs_reg <= req_byte_addr[`LSDMP_OFS_W-1:0];
    end
  end

  reg [`LSDMP_OP_W-1:0] cap_op_reg;
  reg [`LSDMP_OFS_W-1:0] cap_ofs_reg;
  // second stage follows the op into the cycle the memory answers in
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap_op_reg <= `LSDMP_OP_LDW;
      cap_ofs_reg <= 2'h0;
    end else if (!mem_access_enable_n) begin
      cap_op_reg <= pend_op_reg;
      cap_ofs_reg <= pend_ofs_reg;
    end
  end

  // extract and extend the selected lanes; unsigned ops zero-fill
  always @* begin
    load_next = mem_read_data;
    case (cap_op_reg)
      `LSDMP_OP_LOAD_HALF_UNSIGNED_OP: begin
        load_next = lsdmp_extend16(lsdmp_half_pick(mem_read_data, cap_ofs_reg[1]), 1'b0);
      end
      `LSDMP_OP_LDH: begin
        load_next = lsdmp_extend16(lsdmp_half_pick(mem_read_data, cap_ofs_reg[1]), 1'b1);
      end
      `LSDMP_OP_LOAD_BYTE_UNSIGNED_OP: begin
        load_next = lsdmp_extend8(lsdmp_byte_pick(mem_read_data, cap_ofs_reg), 1'b0);
      end
      `LSDMP_OP_LDQ: begin
        load_next = lsdmp_extend8(lsdmp_byte_pick(mem_read_data, cap_ofs_reg), 1'b1);
      end
      `LSDMP_OP_LDW: begin
        load_next = mem_read_data;
      end
      default: begin
        // stores never raise the capture strobe, so this value is unused
        load_next = mem_read_data;
      end
    endcase
  end

  // the unit, not the memory, registers read data
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      load_valid <= 1'b0;
    end else begin
      load_valid <= pend_reg; // R02
    end
  end

  // load data holds until the next load so a late reader still sees it
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      load_data <= {`LSDMP_DATA_W{1'b0}};
    end else if (pend_reg) begin
      load_data <= load_next; // R02
    end
  end
endmodule // lsdmp_port
`default_nettype wire

// ==== test/lsdmp_ram_model.sv ====
// single-port data ram model with one-cycle unregistered read
`timescale 1ns/10ps
`default_nettype none
module lsdmp_ram_model(input wire logic clk_sys,mem_access_enable_n,mem_write_enable_n,
  input wire logic [9:0] mem_word_addr,input wire logic [31:0] mem_write_data,
  input wire logic [3:0] byte_lane_mask,output logic [31:0] mem_read_data);
  logic [31:0] m[1024]='{default:0};
  logic [31:0] q=0;
  logic v=0;
  always @(posedge clk_sys) begin
    v<=!mem_access_enable_n&&mem_write_enable_n;
    if(!mem_access_enable_n&&mem_write_enable_n) q<=m[mem_word_addr];
    for(int i=0;i<4;i++)
      if(!mem_access_enable_n&&!mem_write_enable_n&&byte_lane_mask[i])
        m[mem_word_addr][8*i+:8]<=mem_write_data[8*i+:8];
  end
  // outside a read answer the bus shows junk, so stale data cannot pass
  assign mem_read_data=v?q:~q;
endmodule // lsdmp_ram_model
`default_nettype wire

// ==== test/lsdmp_port_chk.sv ====
// port checker
`timescale 1ns/10ps
`default_nettype none
module lsdmp_port_chk(input wire logic clk_sys,arst_n,req_valid,load_valid,mem_access_enable_n,
  input wire logic mem_write_enable_n,input wire logic [2:0] req_op,
  input wire logic [11:0] req_byte_addr,input wire logic [9:0] mem_word_addr,
  input wire logic [31:0] load_data,mem_read_data,input wire logic [3:0] byte_lane_mask);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_en; mem_access_enable_n==!$past(req_valid); endproperty
  a_en: assert property(p_en) else $error("enable");
  property p_we; req_valid|=>mem_write_enable_n==($past(req_op)<3'h5); endproperty
  a_we: assert property(p_we) else $error("write");
  property p_ad; req_valid|=>mem_word_addr==$past(req_byte_addr[11:2]); endproperty
  a_ad: assert property(p_ad) else $error("address");
  property p_fw; req_valid&&req_op inside {3'h0,3'h5}|=>byte_lane_mask==4'hf; endproperty
  a_fw: assert property(p_fw) else $error("word mask");
  property p_by; req_valid&&req_op inside {3'h2,3'h4,3'h7}|=>
    byte_lane_mask==4'h1<<$past(req_byte_addr[1:0]); endproperty
  a_by: assert property(p_by) else $error("byte mask");
  property p_hw; req_valid&&req_op inside {3'h1,3'h3,3'h6}|=>
    byte_lane_mask==($past(req_byte_addr[1])?4'hc:4'h3); endproperty
  a_hw: assert property(p_hw) else $error("half mask");
  property p_lv; req_valid&&req_op<3'h5|->##3 load_valid; endproperty
  a_lv: assert property(p_lv) else $error("load timing");
  property p_ld; req_valid&&req_op==3'h0|->##3 load_data==$past(mem_read_data); endproperty
  a_ld: assert property(p_ld) else $error("load data");
endmodule // lsdmp_port_chk
bind lsdmp_port lsdmp_port_chk u_chk(.clk_sys(clk_sys),.arst_n(arst_n),.req_valid(req_valid),
  .load_valid(load_valid),.mem_access_enable_n(mem_access_enable_n),
  .mem_write_enable_n(mem_write_enable_n),.req_op(req_op),.req_byte_addr(req_byte_addr),
  .mem_word_addr(mem_word_addr),.load_data(load_data),.mem_read_data(mem_read_data),
  .byte_lane_mask(byte_lane_mask));
`default_nettype wire

// ==== test/testbench.sv ====
// random loads and stores through the port against a shadow memory
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys=0,arst_n=1,req_valid=0,load_valid,mem_access_enable_n,mem_write_enable_n;
  logic [2:0] req_op=0;
  logic [11:0] req_byte_addr=0;
  logic [31:0] req_store_data=0,load_data,mem_write_data,mem_read_data,r=32'h285a,w,h,b;
  logic [31:0] sh[1024]='{default:0},q[$];
  logic [9:0] mem_word_addr;
  logic [3:0] byte_lane_mask;
  int err_total=0,check_count=0;
  lsdmp_port uut(.clk_sys(clk_sys),.arst_n(arst_n),.req_valid(req_valid),.req_op(req_op),
    .req_byte_addr(req_byte_addr),.req_store_data(req_store_data),.load_valid(load_valid),
    .load_data(load_data),.mem_word_addr(mem_word_addr),.mem_write_data(mem_write_data),
    .mem_access_enable_n(mem_access_enable_n),.mem_write_enable_n(mem_write_enable_n),
    .byte_lane_mask(byte_lane_mask),.mem_read_data(mem_read_data));
  lsdmp_ram_model ram(.clk_sys(clk_sys),.mem_access_enable_n(mem_access_enable_n),
    .mem_write_enable_n(mem_write_enable_n),.mem_word_addr(mem_word_addr),
    .mem_write_data(mem_write_data),.byte_lane_mask(byte_lane_mask),
    .mem_read_data(mem_read_data));
  initial forever #2 clk_sys=~clk_sys;
  function logic [31:0] nx(logic [31:0] s);
    return {s[30:0],s[31]^s[21]^s[1]^s[0]};
  endfunction
  task chk(logic [31:0] s,e);
    check_count++;
    if(s!==e) begin
      err_total++;
      $display("unexpected at %0t got %h", $time, s);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d",err_total,check_count);
    if(err_total==0&&check_count>0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task iss(logic [2:0] o,logic [11:0] a,logic [31:0] d);
    w=sh[a[11:2]];
    h=w>>16*a[1];
    b=w>>8*a[1:0];
    @(posedge clk_sys);
    req_valid<=1;
    req_op<=o;
    req_byte_addr<=a;
    req_store_data<=d;
    case(o)
      3'h0: q.push_back(w);
      3'h1: q.push_back({16'h0,h[15:0]});
      3'h2: q.push_back({24'h0,b[7:0]});
      3'h3: q.push_back(32'($signed(h[15:0])));
      3'h4: q.push_back(32'($signed(b[7:0])));
      3'h5: sh[a[11:2]]=d;
      3'h6: sh[a[11:2]][16*a[1]+:16]=d[15:0];
      default: sh[a[11:2]][8*a[1:0]+:8]=d[7:0];
    endcase
  endtask
  always @(posedge clk_sys)
    if(load_valid===1'b1) chk(load_data,q.size()?q.pop_front():~load_data);
  initial begin
    #1 arst_n=0;
    repeat(12) @(posedge clk_sys);
    arst_n<=1;
    repeat(900) begin
      r=nx(r);
      iss(r[2:0],{6'h0,r[10:5]},r);
      if(r[15]) @(posedge clk_sys) req_valid<=0;
    end
    @(posedge clk_sys) req_valid<=0;
    for(int i=0;i<9&&q.size()>0;i++) @(posedge clk_sys);
    if(q.size()>0) chk(32'h0,32'h1);
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
